// ==== verilog/iex_pkg.sv ====
// Shared constants and types for the instruction execution subset.
`default_nettype none
package iex_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PADDR_W = 11;
  localparam int PWORD_W = 14;
  localparam int BADDR_W = 8;
  localparam int TABLE_PTR_USED = 3;
  localparam int TABLE_DATA_USED = 6;

  // Register port map.
  localparam logic [7:0] ADDR_FILE_LAST = 8'h7F;
  localparam logic [7:0] ADDR_ACC = 8'h80;
  localparam logic [7:0] ADDR_TMODE = 8'h81;
  localparam logic [7:0] ADDR_TABLE_PTR = 8'h82;
  localparam logic [7:0] ADDR_TABLE_DATA = 8'h83;
  localparam logic [7:0] ADDR_STATUS = 8'h84;

  // Status register fields.
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // Reset values.
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TMODE_RST = 8'h00;
  localparam logic [7:0] TABLE_PTR_RST = 8'h00;
  localparam logic [7:0] TABLE_DATA_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;

  // Cycle counts of the instructions.
  localparam int CYC_SINGLE = 1;
  localparam int CYC_TABLE = 2;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_NIBBLE_SWAP = 3'h1,
    OP_LOAD_TIMER_MODE = 3'h2,
    OP_READ_TIMER_MODE = 3'h3,
    OP_TABLE_READ = 3'h4,
    OP_XOR_REG = 3'h5,
    OP_XOR_IMMEDIATE = 3'h6
  } iex_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_TABLE = 1'b1
  } iex_state_t;
endpackage
`default_nettype wire

// ==== verilog/iex_regfile.sv ====
// File register array with two read ports and one write port.
`timescale 1ns/1ps
`default_nettype none
module iex_regfile (
  input wire logic mclk,
  input wire logic wrEn,
  input wire logic [6:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [6:0] rdAddrA,
  output logic [7:0] rdDataA,
  input wire logic [6:0] rdAddrB,
  output logic [7:0] rdDataB
);
  // File registers are plain storage and hold no reset value.
  logic [7:0] mem [0:127];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];
endmodule
`default_nettype wire

// ==== verilog/iex_progmem.sv ====
// Program memory of 14-bit words with a load port and a clocked read.
`timescale 1ns/1ps
`default_nettype none
module iex_progmem (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [10:0] wrAddr,
  input wire logic [13:0] wrData,
  input wire logic rdEn,
  input wire logic [10:0] rdAddr,
  output logic [13:0] rdData
);
  logic [13:0] mem [0:2047];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 14'h0000;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

// ==== verilog/iex_core.sv ====
// Execution core for swap, timer-mode moves, table read and XOR.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module iex_core (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [2:0] instrOp,
  input wire logic [6:0] instrAddr,
  input wire logic instrDest,
  input wire logic [7:0] instrImm,
  output logic busy,
  output logic done,
  output logic [7:0] accOut,
  output logic [7:0] timerModeOut,
  output logic zeroFlag,
  input wire logic progWrite,
  input wire logic [10:0] progAddr,
  input wire logic [13:0] progData,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData
);
  iex_pkg::iex_state_t state_q;
  iex_pkg::iex_state_t state_d;
  iex_pkg::iex_op_t op;

  logic [7:0] acc_q;
  logic [7:0] timerMode_q;
  logic [7:0] tableHighPointer_q;
  logic [7:0] tableHighData_q;
  logic zero_q;
  logic done_q;
  logic [7:0] rdData_q;

  logic accept;
  logic [7:0] fileVal;
  logic [7:0] busFileVal;
  logic [7:0] swapVal;
  logic [7:0] xorRegVal;
  logic [7:0] xorImmVal;
  logic [13:0] romWord;
  logic [10:0] romAddr;
  logic romRead;
  logic tableFinish;

  logic instAccWe;
  logic [7:0] instAccD;
  logic instFileWe;
  logic [7:0] instFileD;
  logic instZeroWe;
  logic instZeroD;
  logic instTmodeWe;

  logic busFileWe;
  logic fileWe;
  logic [6:0] fileWrAddr;
  logic [7:0] fileWrData;
  logic busHit;

  // A new instruction is taken only while no table read is pending.
  assign accept = instrValid && (state_q == iex_pkg::ST_IDLE);
  assign tableFinish = (state_q == iex_pkg::ST_TABLE);

  always_comb begin
    op = iex_pkg::OP_NOP;
    if (accept) begin
      case (instrOp)
        3'h1: op = iex_pkg::OP_NIBBLE_SWAP;
        3'h2: op = iex_pkg::OP_LOAD_TIMER_MODE;
        3'h3: op = iex_pkg::OP_READ_TIMER_MODE;
        3'h4: op = iex_pkg::OP_TABLE_READ;
        3'h5: op = iex_pkg::OP_XOR_REG;
        3'h6: op = iex_pkg::OP_XOR_IMMEDIATE;
        default: op = iex_pkg::OP_NOP;
      endcase
    end
  end

  assign swapVal = {fileVal[3:0], fileVal[7:4]};
  assign xorRegVal = acc_q ^ fileVal;
  assign xorImmVal = acc_q ^ instrImm;

  // Pointer bits above the accumulator select the program word.
  assign romAddr = {tableHighPointer_q[2:0], acc_q};
  assign romRead = (op == iex_pkg::OP_TABLE_READ);

  always_comb begin
    instAccWe = 1'b0;
    instAccD = acc_q;
    instFileWe = 1'b0;
    instFileD = fileVal;
    instZeroWe = 1'b0;
    instZeroD = zero_q;
    instTmodeWe = 1'b0;
    if (tableFinish) begin
      instAccWe = 1'b1;
      instAccD = romWord[7:0];
    end
    case (op)
      iex_pkg::OP_NIBBLE_SWAP: begin
        if (instrDest) begin
          instFileWe = 1'b1;
          instFileD = swapVal;
        end else begin
          instAccWe = 1'b1;
          instAccD = swapVal;
        end
      end
      iex_pkg::OP_LOAD_TIMER_MODE: begin
        instTmodeWe = 1'b1;
      end
      iex_pkg::OP_READ_TIMER_MODE: begin
        instAccWe = 1'b1;
        instAccD = timerMode_q;
      end
      iex_pkg::OP_XOR_REG: begin
        if (instrDest) begin
          instFileWe = 1'b1;
          instFileD = xorRegVal;
        end else begin
          instAccWe = 1'b1;
          instAccD = xorRegVal;
        end
        instZeroWe = 1'b1;
        instZeroD = (xorRegVal == 8'h00);
      end
      iex_pkg::OP_XOR_IMMEDIATE: begin
        instAccWe = 1'b1;
        instAccD = xorImmVal;
        instZeroWe = 1'b1;
        instZeroD = (xorImmVal == 8'h00);
      end
      default: begin
        instAccWe = instAccWe;
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      iex_pkg::ST_IDLE: begin
        if (op == iex_pkg::OP_TABLE_READ) begin
          state_d = iex_pkg::ST_TABLE;
        end
      end
      iex_pkg::ST_TABLE: begin
        state_d = iex_pkg::ST_IDLE;
      end
      default: begin
        state_d = iex_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= iex_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The instruction owns the file write port; a software write that
  // collides with an instruction write in the same cycle is dropped.
  assign busFileWe = regWrite && (regAddr <= iex_pkg::ADDR_FILE_LAST);
  assign fileWe = instFileWe || busFileWe;
  assign fileWrAddr = instFileWe ? instrAddr : regAddr[6:0];
  assign fileWrData = instFileWe ? instFileD : regWrData;

  iex_regfile u_regfile (
    .mclk(mclk),
    .wrEn(fileWe),
    .wrAddr(fileWrAddr),
    .wrData(fileWrData),
    .rdAddrA(instrAddr),
    .rdDataA(fileVal),
    .rdAddrB(regAddr[6:0]),
    .rdDataB(busFileVal)
  );

  iex_progmem u_progmem (
    .mclk(mclk),
    .rst_n(rst_n),
    .wrEn(progWrite),
    .wrAddr(progAddr),
    .wrData(progData),
    .rdEn(romRead),
    .rdAddr(romAddr),
    .rdData(romWord)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= iex_pkg::ACC_RST;
    end else if (instAccWe) begin
      acc_q <= instAccD;
    end else if (regWrite && regAddr == iex_pkg::ADDR_ACC) begin
      acc_q <= regWrData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timerMode_q <= iex_pkg::TMODE_RST;
    end else if (instTmodeWe) begin
      timerMode_q <= acc_q;
    end else if (regWrite && regAddr == iex_pkg::ADDR_TMODE) begin
      timerMode_q <= regWrData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tableHighPointer_q <= iex_pkg::TABLE_PTR_RST;
    end else if (regWrite && regAddr == iex_pkg::ADDR_TABLE_PTR) begin
      tableHighPointer_q <= regWrData;
    end
  end

  // Only the low six bits follow the fetched word; the top two keep
  // whatever software last wrote.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tableHighData_q <= iex_pkg::TABLE_DATA_RST;
    end else if (tableFinish) begin
      tableHighData_q[5:0] <= romWord[13:8];
    end else if (regWrite && regAddr == iex_pkg::ADDR_TABLE_DATA) begin
      tableHighData_q <= regWrData;
    end
  end

  // An instruction result wins over a software write in the same cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      zero_q <= iex_pkg::ZERO_RST;
    end else if (instZeroWe) begin
      zero_q <= instZeroD;
    end else if (regWrite && regAddr == iex_pkg::ADDR_STATUS) begin
      zero_q <= regWrData[iex_pkg::STAT_ZERO_BIT];
    end
  end

  // Done pulses once per finished instruction, after the last cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= tableFinish ||
                (op != iex_pkg::OP_NOP && op != iex_pkg::OP_TABLE_READ);
    end
  end

  assign busHit = regAddr <= iex_pkg::ADDR_STATUS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
    end else if (regRead) begin
      rdData_q <= 8'h00;
      if (regAddr <= iex_pkg::ADDR_FILE_LAST) begin
        rdData_q <= busFileVal;
      end else if (busHit) begin
        case (regAddr)
          iex_pkg::ADDR_ACC: rdData_q <= acc_q;
          iex_pkg::ADDR_TMODE: rdData_q <= timerMode_q;
          iex_pkg::ADDR_TABLE_PTR: rdData_q <= tableHighPointer_q;
          iex_pkg::ADDR_TABLE_DATA: rdData_q <= tableHighData_q;
          iex_pkg::ADDR_STATUS: begin
            rdData_q[iex_pkg::STAT_ZERO_BIT] <= zero_q;
            rdData_q[iex_pkg::STAT_BUSY_BIT] <= tableFinish;
          end
          default: rdData_q <= 8'h00;
        endcase
      end
    end
  end

  assign busy = tableFinish;
  assign done = done_q;
  assign accOut = acc_q;
  assign timerModeOut = timerMode_q;
  assign zeroFlag = zero_q;
  assign regRdData = rdData_q;
endmodule
`default_nettype wire

// ==== tb/iex_core_props.sv ====
// Checker of the execution core's instruction port behaviour.
`timescale 1ns/1ps
`default_nettype none
module iex_core_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [2:0] instrOp,
  input wire logic instrDest,
  input wire logic [7:0] instrImm,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] accOut,
  input wire logic [7:0] timerModeOut,
  input wire logic zeroFlag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = instrValid && !busy;
  a_table_two_cyc: assert property (take && instrOp == 3'h4 |=>
    busy && !done ##1 !busy && done) else $error("table read timing");
  a_single_done: assert property (take && instrOp inside {3'h1, 3'h2,
    3'h3, 3'h5, 3'h6} |=> done && !busy) else $error("one cycle op late");
  a_swap_reg_keep: assert property (take && instrOp == 3'h1 && instrDest
    |=> $stable(accOut) && $stable(zeroFlag)) else $error("swap to reg");
  a_load_mode: assert property (take && instrOp == 3'h2 |=>
    timerModeOut == $past(accOut) && $stable(accOut) && $stable(zeroFlag))
    else $error("load timer mode");
  a_read_mode: assert property (take && instrOp == 3'h3 |=>
    accOut == $past(timerModeOut) && $stable(timerModeOut)
    && $stable(zeroFlag)) else $error("read timer mode");
  a_xor_reg_dest: assert property (take && instrOp == 3'h5 && instrDest
    |=> $stable(accOut)) else $error("xor to reg moved acc");
  a_xor_imm_val: assert property (take && instrOp == 3'h6 |=>
    accOut == ($past(accOut) ^ $past(instrImm))) else $error("xor imm");
  a_xor_zero: assert property (take && (instrOp == 3'h6 ||
    instrOp == 3'h5 && !instrDest) |=> zeroFlag == (accOut == 8'h00))
    else $error("zero flag wrong");
endmodule
bind iex_core iex_core_props u_props (.mclk, .rst_n, .instrValid,
  .instrOp, .instrDest, .instrImm, .busy, .done, .accOut, .timerModeOut,
  .zeroFlag);
`default_nettype wire

// ==== tb/iex_core_tb_top.sv ====
// Self-checking bench for the instruction execution core.
`timescale 1ns/1ps
`default_nettype none
module iex_core_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0;
  logic instrDest = 1'b0;
  logic [2:0] instrOp = 3'h0;
  logic [6:0] instrAddr = 7'h00;
  logic [7:0] instrImm = 8'h00;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic progWrite = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [10:0] progAddr = 11'h000;
  logic [13:0] progData = 14'h0000;
  logic busy, done, zeroFlag;
  logic [7:0] accOut, timerModeOut, regRdData;
  int failures = 0;
  int comparisons = 0;
  integer seed = 32'hb8e5;
  logic [7:0] fm [128];
  logic [7:0] mAcc, mTm, im, r;
  logic [2:0] op;
  logic [6:0] a;
  logic d, mZ;
  logic [2:0] ops [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  always #4 mclk = ~mclk;
  iex_core uut (.mclk, .rst_n, .instrValid, .instrOp, .instrAddr,
    .instrDest, .instrImm, .busy, .done, .accOut, .timerModeOut,
    .zeroFlag, .progWrite, .progAddr, .progData, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData);
  task automatic chk(input string nm, input logic [13:0] seen,
    input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Each strobe is dropped an edge before the next request may raise it.
  task automatic regWr(input logic [7:0] ad, input logic [7:0] dt);
    regAddr <= ad;
    regWrData <= dt;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic regRd(input logic [7:0] ad, input logic [7:0] e);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 chk("regRdData", regRdData, e);
    @(posedge mclk);
  endtask
  task automatic exec;
    int n;
    instrValid <= 1'b1;
    instrOp <= op;
    instrAddr <= a;
    instrDest <= d;
    instrImm <= im;
    @(posedge mclk);
    instrValid <= 1'b0;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 3) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("done", done, 1'b1);
    @(posedge mclk);
  endtask
  function automatic void predict;
    case (op)
      3'h1: begin
        r = {fm[a][3:0], fm[a][7:4]};
        if (d) fm[a] = r;
        else mAcc = r;
      end
      3'h2: mTm = mAcc;
      3'h3: mAcc = mTm;
      3'h5: begin
        r = mAcc ^ fm[a];
        mZ = (r == 8'h00);
        if (d) fm[a] = r;
        else mAcc = r;
      end
      default: begin
        mAcc = mAcc ^ im;
        mZ = (mAcc == 8'h00);
      end
    endcase
  endfunction
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 chk("accOut", accOut, 8'h00);
    chk("timerModeOut", timerModeOut, 8'h00);
    chk("busy", {busy, done, zeroFlag}, 3'h0);
    @(posedge mclk);
    regRd(8'h83, 8'h00);
    regRd(8'h85, 8'h00);
    $display("Reset test done");
    for (int i = 0; i < 128; i++) begin
      fm[i] = $random(seed);
      regWr(i[7:0], fm[i]);
    end
    mAcc = $random(seed);
    regWr(8'h80, mAcc);
    {mTm, mZ} = 9'h000;
    for (int i = 0; i < 80; i++) begin
      op = ops[$unsigned($random(seed)) % 5];
      {a, d, im} = $random(seed);
      // Every eighth step forces an all-zero result onto the flag.
      if (i % 8 == 0) begin
        op = 3'h6;
        im = mAcc;
      end
      predict();
      exec();
      chk("accOut", accOut, mAcc);
      chk("timerModeOut", timerModeOut, mTm);
      chk("zeroFlag", zeroFlag, mZ);
      regRd({1'b0, a}, fm[a]);
    end
    $display("Random test done");
    progWrite <= 1'b1;
    progAddr <= 11'h234;
    progData <= 14'h35AA;
    @(posedge mclk);
    progWrite <= 1'b0;
    regWr(8'h82, 8'hFA);
    regWr(8'h80, 8'h34);
    regWr(8'h83, 8'hC1);
    instrValid <= 1'b1;
    instrOp <= 3'h4;
    @(posedge mclk);
    instrOp <= 3'h6;
    instrImm <= 8'hFF;
    // The status read lands in the busy cycle to see the busy bit set.
    regAddr <= 8'h84;
    regRead <= 1'b1;
    #1 chk("busy", busy, 1'b1);
    @(posedge mclk);
    instrValid <= 1'b0;
    regRead <= 1'b0;
    #1 chk("done", done, 1'b1);
    chk("status", regRdData, {6'h00, 1'b1, mZ});
    @(posedge mclk);
    #1 chk("accOut", accOut, 8'hAA);
    @(posedge mclk);
    regRd(8'h83, 8'hF5);
    regWr(8'h84, 8'hFF);
    regRd(8'h84, 8'h01);
    chk("zeroFlag", zeroFlag, 1'b1);
    regRd(8'h82, 8'hFA);
    // An unused opcode must neither finish nor move the accumulator.
    instrValid <= 1'b1;
    instrOp <= 3'h7;
    @(posedge mclk);
    instrValid <= 1'b0;
    #1 chk("nop done", done, 1'b0);
    chk("nop acc", accOut, 8'hAA);
    $display("Table test done");
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
